//--- pcm_counter_ctrl.sv
// control and mode logic of the counter array with watchdog on module 2
`timescale 1ns/1ns
module pcm_counter_ctrl #(
    parameter int PRESCALE = pcm_pkg::PRESCALE_DIV,
    parameter int EXT_DIV  = pcm_pkg::EXT_CLK_DIV
) (
    // clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_reset,
    // special function register port
    input  wire pcm_pkg::pcm_sfr_req_t i_sfr,
    output logic [7:0]                 o_sfr_rdata,
    // timebase sources and idle input
    input  wire logic                  i_timer0_ovf,
    input  wire logic                  i_ext_count,
    input  wire logic                  i_ext_clk,
    input  wire logic                  i_idle,
    // capture/compare modules
    input  wire logic [2:0]            i_mod_event,
    input  wire logic [2:0]            i_ccf_irq_en,
    input  wire logic [7:0]            i_mod2_offset,
    input  wire logic                  i_mod2_high_wr,
    // status
    output logic [15:0]                o_counter,
    output logic                       o_irq,
    output logic                       o_watchdog_reset,
    output logic                       o_watchdog_active
);
    import pcm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks
    if (PRESCALE % 4 != 0 || PRESCALE < 4 || PRESCALE > 16) begin : g_chk_pre
        $error("PRESCALE must be a multiple of 4 between 4 and 16");
    end
    if (EXT_DIV != 8) begin : g_chk_ext
        $error("EXT_DIV must be 8 for the 3-bit divider");
    end

    localparam logic [3:0] PRE_LAST = 4'(PRESCALE - 1);
    localparam pcm_state_t ST_RST   = '{wd_enable: 1'b1, default: '0};

    ////////////////////////////////////////////////////////////////////////
    // state and decode
    pcm_state_t s;
    pcm_state_t next_s;
    logic       ctrl_wr;
    logic       mode_wr;
    logic       ext_fall;
    logic       eclk_rise;
    logic       tick;
    logic       run;
    logic       step;
    logic       wrap;
    logic       low_ovf;
    logic       wd_match;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_s   = s;
        ctrl_wr  = i_sfr.wr && (i_sfr.addr == ADDR_CTRL);
        mode_wr  = i_sfr.wr && (i_sfr.addr == ADDR_MODE);

        // pin synchronisers; first flop feeds only the second
        next_s.ecnt_sync = {s.ecnt_sync[1:0], i_ext_count};
        next_s.eclk_sync = {s.eclk_sync[1:0], i_ext_clk};
        ext_fall  = s.ecnt_sync[2] & ~s.ecnt_sync[1];
        eclk_rise = ~s.eclk_sync[2] & s.eclk_sync[1];

        // external clock divider, free running
        if (eclk_rise) begin
            next_s.ext_div = 3'(s.ext_div + 3'h1);
        end

        // prescaler free runs from reset
        next_s.prescale = (s.prescale == PRE_LAST) ? 4'h0
                        : 4'(s.prescale + 4'h1);

        // timebase select; reserved codes never tick
        case (s.timebase_sel)
            TB_SYS_DIV12: begin
                tick = (s.prescale == PRE_LAST);
            end
            TB_SYS_DIV4: begin
                tick = (s.prescale[1:0] == 2'h3);
            end
            TB_TIMER0: begin
                tick = i_timer0_ovf;
            end
            TB_EXT_FALL: begin
                tick = ext_fall;
            end
            TB_SYS: begin
                tick = 1'b1;
            end
            TB_EXT_DIV8: begin
                tick = eclk_rise && (s.ext_div == 3'h7);
            end
            default: begin
                tick = 1'b0;
            end
        endcase

        // watchdog forces the counter on; idle suspend halts the counter even then, prescaler keeps running
        run      = (s.run_bit | s.wd_enable)
                 & ~(s.idle_suspend & i_idle);
        step     = run & tick;
        wrap     = step && (s.count == COUNT_MAX);
        low_ovf  = step && (s.count[7:0] == LOW_MAX);
        wd_match = low_ovf && (s.count[15:8] == s.mod2_high);
        if (step) begin
            next_s.count = 16'(s.count + 16'h1);
        end

        // watchdog expiry or forced expiry, one cycle pulse
        next_s.wd_reset = s.wd_enable
                        && (wd_match
                        || (ctrl_wr && i_sfr.wdata[CTRL_MOD2_BIT]));
        if (i_mod2_high_wr) begin
            next_s.mod2_high = 8'(s.count[15:8] + i_mod2_offset);
        end

        // control register; bits 5:3 are not stored
        if (ctrl_wr) begin
            next_s.ovf_flag = i_sfr.wdata[CTRL_OVF_BIT];
            next_s.run_bit  = i_sfr.wdata[CTRL_RUN_BIT];
            next_s.mod_flag = i_sfr.wdata[CTRL_MOD2_BIT:0];
        end

        // hardware set wins over a software clear in the same cycle
        if (wrap) begin
            next_s.ovf_flag = 1'b1;
        end
        next_s.mod_flag = next_s.mod_flag | i_mod_event;

        // mode register; only the enable moves while enabled
        if (mode_wr) begin
            if (s.wd_enable) begin
                if (!s.wd_lock) begin
                    next_s.wd_enable = i_sfr.wdata[MODE_WDEN_BIT];
                end
            end else begin
                next_s.idle_suspend = i_sfr.wdata[MODE_IDLE_BIT];
                next_s.wd_lock      = i_sfr.wdata[MODE_LOCK_BIT];
                next_s.wd_enable    = i_sfr.wdata[MODE_WDEN_BIT]
                                    | i_sfr.wdata[MODE_LOCK_BIT];
                next_s.timebase_sel = i_sfr.wdata[MODE_TB_LSB +: 3];
                next_s.ovf_irq_mask = i_sfr.wdata[MODE_MASK_BIT];
            end
        end
        if (s.wd_lock) begin
            next_s.wd_enable = 1'b1;
        end

        // shared interrupt request
        next_s.irq = (s.ovf_flag & s.ovf_irq_mask)
                   | (|(s.mod_flag & i_ccf_irq_en));

        // read data, one cycle behind the address
        case (i_sfr.addr)
            ADDR_CTRL: begin
                next_s.rdata = {s.ovf_flag, s.run_bit, 3'h0,
                                s.mod_flag};
            end
            ADDR_MODE: begin
                next_s.rdata = {s.idle_suspend, s.wd_enable, s.wd_lock,
                                1'b0, s.timebase_sel, s.ovf_irq_mask};
            end
            default: begin
                next_s.rdata = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            s <= ST_RST;
        end else begin
            s <= next_s;
        end
    end

    assign o_sfr_rdata       = s.rdata;
    assign o_counter         = s.count;
    assign o_irq             = s.irq;
    assign o_watchdog_reset  = s.wd_reset;
    assign o_watchdog_active = s.wd_enable;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    AST_OVF_SET: assert property (
        step && s.count == COUNT_MAX |=> s.ovf_flag && s.count == 16'h0000)
        else $error("overflow flag not set on wrap");

    AST_OVF_STICKY: assert property (
        s.ovf_flag && !ctrl_wr |=> s.ovf_flag)
        else $error("overflow flag cleared without software");

    AST_OVF_CLEAR: assert property (
        ctrl_wr && !i_sfr.wdata[CTRL_OVF_BIT] && !wrap |=> !s.ovf_flag)
        else $error("overflow flag not cleared by software");

    AST_IRQ_OVF: assert property (
        s.ovf_flag && s.ovf_irq_mask |=> o_irq)
        else $error("unmasked overflow gave no interrupt");

    AST_IRQ_OFF: assert property (
        !(s.ovf_flag && s.ovf_irq_mask)
        && (s.mod_flag & i_ccf_irq_en) == 3'h0 |=> !o_irq)
        else $error("interrupt raised with nothing unmasked");

    AST_STOPPED: assert property (
        !s.run_bit && !s.wd_enable |=> $stable(s.count))
        else $error("counter moved while stopped");

    AST_WR_RUN: assert property (
        ctrl_wr |=> s.run_bit == $past(i_sfr.wdata[CTRL_RUN_BIT]))
        else $error("run bit did not take the written value");

    AST_MOD_FLAG: assert property (
        i_mod_event != 3'h0 |=> (s.mod_flag & $past(i_mod_event))
                                == $past(i_mod_event))
        else $error("module event did not set its flag");

    AST_FLAG_CLEAR: assert property (
        ctrl_wr && i_sfr.wdata[2:0] == 3'h0 && i_mod_event == 3'h0
        |=> s.mod_flag == 3'h0)
        else $error("module flags not cleared by software");

    AST_IRQ_MOD: assert property (
        (s.mod_flag & i_ccf_irq_en) != 3'h0 |=> o_irq)
        else $error("unmasked module flag gave no interrupt");

    AST_RSVD_ZERO: assert property (
        i_sfr.addr == ADDR_CTRL |=> o_sfr_rdata[5:3] == 3'h0)
        else $error("unused control bits read nonzero");

    AST_MODE_BIT4: assert property (
        i_sfr.addr == ADDR_MODE |=> o_sfr_rdata[4] == 1'b0)
        else $error("unused mode bit read nonzero");

    AST_UNMAPPED: assert property (
        i_sfr.addr != ADDR_CTRL && i_sfr.addr != ADDR_MODE
        |=> o_sfr_rdata == 8'h00)
        else $error("unmapped address read nonzero");

    AST_IDLE_HALT: assert property (
        s.idle_suspend && i_idle |=> $stable(s.count))
        else $error("counter moved during suspended idle");

    AST_WD_OFF: assert property (
        mode_wr && s.wd_enable && !s.wd_lock
        && !i_sfr.wdata[MODE_WDEN_BIT] |=> !o_watchdog_active)
        else $error("watchdog not disabled by mode write");

    AST_WD_ON: assert property (
        mode_wr && !s.wd_enable && i_sfr.wdata[MODE_WDEN_BIT]
        |=> o_watchdog_active)
        else $error("watchdog not enabled by mode write");

    AST_LOCK_HOLD: assert property (
        s.wd_lock |=> s.wd_enable && s.wd_lock)
        else $error("locked watchdog was disabled");

    AST_RSVD_CODE: assert property (
        s.timebase_sel[2:1] == 2'h3 |-> !tick)
        else $error("reserved timebase code ticked");

    AST_PRE_RANGE: assert property (
        s.prescale <= PRE_LAST)
        else $error("prescaler out of range");

    AST_EXT_ONCE: assert property (
        ext_fall |=> !ext_fall)
        else $error("one falling edge counted twice");

    AST_MODE_FROZEN: assert property (
        s.wd_enable && mode_wr |=> $stable(s.timebase_sel)
        && $stable(s.idle_suspend) && $stable(s.ovf_irq_mask)
        && $stable(s.wd_lock))
        else $error("mode bits changed while watchdog enabled");

    AST_WDT_FORCE: assert property (
        s.wd_enable && ctrl_wr && i_sfr.wdata[CTRL_MOD2_BIT]
        |=> o_watchdog_reset)
        else $error("forced watchdog reset missing");

    AST_WDT_EXPIRE: assert property (
        s.wd_enable && wd_match |=> o_watchdog_reset)
        else $error("watchdog expiry gave no reset");

    AST_WD_QUIET: assert property (
        !s.wd_enable |=> !o_watchdog_reset)
        else $error("watchdog reset while disabled");

    AST_RELOAD: assert property (
        i_mod2_high_wr |=> s.mod2_high == 8'($past(s.count[15:8])
                                             + $past(i_mod2_offset)))
        else $error("module 2 high byte reload wrong");

    AST_SYS_TICK: assert property (
        run && s.timebase_sel == TB_SYS
        |=> s.count == 16'($past(s.count) + 16'h1))
        else $error("system clock timebase did not count");

    AST_STEP_COUNT: assert property (
        step |=> s.count == 16'($past(s.count) + 16'h1))
        else $error("counter did not step on a tick");

    AST_NO_STEP: assert property (
        !step |=> $stable(s.count))
        else $error("counter moved without a tick");

    ////////////////////////////////////////////////////////////////////////
    // covers
    COV_WRAP:     cover property (wrap);
    COV_WDT_FIRE: cover property (s.wd_enable && wd_match);
    COV_EXT_TICK: cover property (step && s.timebase_sel == TB_EXT_FALL);
    COV_LOCKED:   cover property (s.wd_lock && mode_wr);
    COV_DIV8:     cover property (step && s.timebase_sel == TB_EXT_DIV8);
endmodule // pcm_counter_ctrl

//--- pcm_counter_ctrl_tb.sv
// self-checking bench for the counter array control block
`timescale 1ns/1ns
module pcm_counter_ctrl_tb;
    import pcm_pkg::*;
    logic          clk  = 1'b0;
    logic          rst  = 1'b1;
    logic          t0   = 1'b0;
    logic          ecnt = 1'b0;
    logic          eclk = 1'b0;
    logic          idle = 1'b0;
    logic          m2wr = 1'b0;
    logic [2:0]    ev   = 3'h0;
    logic [2:0]    en   = 3'h0;
    logic [7:0]    off  = 8'h00;
    logic [7:0]    rdat;
    logic [15:0]   cnt;
    logic [15:0]   c0;
    logic [15:0]   sd   = 16'h7CC1;
    pcm_sfr_req_t  sfr  = '0;
    logic          irq;
    logic          wdr;
    logic          wda;
    int            err_count = 0;
    int            cmp_count = 0;
    int            n;
    int            nt;
    int            nf;
    int            nr;

    always #20 clk = ~clk;

    pcm_counter_ctrl #(.PRESCALE(12), .EXT_DIV(8)) dut_u (
        .i_ref_clk(clk), .i_reset(rst), .i_sfr(sfr), .o_sfr_rdata(rdat),
        .i_timer0_ovf(t0), .i_ext_count(ecnt), .i_ext_clk(eclk),
        .i_idle(idle), .i_mod_event(ev), .i_ccf_irq_en(en),
        .i_mod2_offset(off), .i_mod2_high_wr(m2wr), .o_counter(cnt),
        .o_irq(irq), .o_watchdog_reset(wdr), .o_watchdog_active(wda));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] exp_ticks(input logic [2:0] c,
                                              input int t, f, r);
        case (c)
            TB_SYS_DIV12: return 16'(96 / PRESCALE_DIV);
            TB_SYS_DIV4:  return 16'(96 / 4);
            TB_TIMER0:    return 16'(t);
            TB_EXT_FALL:  return 16'(f);
            TB_SYS:       return 16'(96);
            TB_EXT_DIV8:  return 16'(r / EXT_CLK_DIV);
            default:      return 16'h0000;
        endcase
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, d);
        tick(1);
        sfr = '{a, 1'b1, d};
        tick(1);
        sfr.wr = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, exp);
        tick(1);
        sfr.addr = a;
        tick(1);
        chk("sfr_rdata", {8'h00, exp}, {8'h00, rdat});
    endtask
    task automatic wait_rst(input int lim);
        n = 0;
        while (wdr !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #4000000;
        err_count++;
        summarize();
    end

    initial begin
        tick(5);
        rst = 1'b0;
        chk("watchdog_active", 16'h0001, {15'h0, wda});
        rdc(ADDR_CTRL, 8'h00);
        rdc(ADDR_MODE, 8'h40);
        sd = lfsr(sd);
        wr(ADDR_MODE, sd[7:0] | 8'h40);
        rdc(ADDR_MODE, 8'h40);
        wr(ADDR_MODE, 8'h08);
        rdc(ADDR_MODE, 8'h00);
        wr(ADDR_MODE, 8'h08);
        rdc(ADDR_MODE, 8'h08);
        chk("watchdog_active", 16'h0000, {15'h0, wda});
        wr(ADDR_CTRL, 8'h78);
        rdc(ADDR_CTRL, 8'h40);
        // run to the wrap with the overflow mask off
        n = 0;
        while (cnt !== COUNT_MAX && n < 70000) begin
            tick(1);
            n++;
        end
        tick(2);
        chk("irq", 16'h0000, {15'h0, irq});
        rdc(ADDR_CTRL, 8'hC0);
        wr(ADDR_MODE, 8'h09);
        tick(2);
        chk("irq", 16'h0001, {15'h0, irq});
        wr(ADDR_CTRL, 8'h40);
        tick(2);
        chk("irq", 16'h0000, {15'h0, irq});
        wr(ADDR_CTRL, 8'h00);
        tick(2);
        c0 = cnt;
        tick(5);
        chk("counter", c0, cnt);
        wr(ADDR_CTRL, 8'h40);
        wr(ADDR_MODE, 8'h88);
        idle = 1'b1;
        tick(2);
        c0 = cnt;
        tick(10);
        chk("counter", c0, cnt);
        wr(ADDR_MODE, 8'h08);
        tick(2);
        c0 = cnt;
        tick(10);
        chk("counter", c0 + 16'h000A, cnt);
        idle = 1'b0;
        // every timebase code over a 96-edge window
        for (int code = 0; code < 8; code++) begin
            wr(ADDR_MODE, {4'h0, code[2:0], 1'b0});
            tick(2);
            c0 = cnt;
            nt = 0;
            nf = 0;
            nr = 0;
            for (int i = 0; i < 88; i++) begin
                nf += int'(ecnt && !i[2]);
                nr += int'(!eclk && i[0] && i < 64);
                nt += int'(i[0]);
                t0 = i[0];
                ecnt = i[2];
                eclk = i[0] && i < 64;
                tick(1);
            end
            nf += int'(ecnt);
            t0 = 1'b0;
            ecnt = 1'b0;
            tick(8);
            chk("counter", c0 + exp_ticks(code[2:0], nt, nf, nr), cnt);
        end
        wr(ADDR_MODE, 8'h00);
        repeat (6) begin
            sd = lfsr(sd);
            tick(1);
            ev = sd[2:0];
            en = sd[5:3];
            tick(1);
            ev = 3'h0;
            tick(2);
            chk("irq", {15'h0, |(sd[2:0] & sd[5:3])}, {15'h0, irq});
            rdc(ADDR_CTRL, {5'h08, sd[2:0]});
            wr(ADDR_CTRL, 8'h40);
        end
        // watchdog: update with offset 1, then a forced reset
        wr(ADDR_MODE, 8'h48);
        tick(1);
        c0 = cnt;
        off = 8'h01;
        m2wr = 1'b1;
        tick(1);
        m2wr = 1'b0;
        wait_rst(600);
        chk("wd_window", 16'h0001,
            {15'h0, n >= 509 - c0[7:0] && n <= 513 - c0[7:0]});
        wr(ADDR_CTRL, 8'h44);
        wait_rst(3);
        chk("forced_reset", 16'h0001, {15'h0, wdr});
        wr(ADDR_MODE, 8'h08);
        wr(ADDR_MODE, 8'h20);
        rdc(ADDR_MODE, 8'h60);
        wr(ADDR_MODE, 8'h00);
        rdc(ADDR_MODE, 8'h60);
        summarize();
    end
endmodule // pcm_counter_ctrl_tb

//--- pcm_pkg.sv
// constants, carriers and state layout for the counter array control block
package pcm_pkg;
    localparam logic [7:0] ADDR_CTRL      = 8'hD8;
    localparam logic [7:0] ADDR_MODE      = 8'hD9;
    localparam int         CTRL_OVF_BIT   = 7;
    localparam int         CTRL_RUN_BIT   = 6;
    localparam int         CTRL_MOD2_BIT  = 2;
    localparam int         MODE_IDLE_BIT  = 7;
    localparam int         MODE_WDEN_BIT  = 6;
    localparam int         MODE_LOCK_BIT  = 5;
    localparam int         MODE_TB_LSB    = 1;
    localparam int         MODE_MASK_BIT  = 0;
    localparam logic [2:0] TB_SYS_DIV12   = 3'h0;
    localparam logic [2:0] TB_SYS_DIV4    = 3'h1;
    localparam logic [2:0] TB_TIMER0      = 3'h2;
    localparam logic [2:0] TB_EXT_FALL    = 3'h3;
    localparam logic [2:0] TB_SYS         = 3'h4;
    localparam logic [2:0] TB_EXT_DIV8    = 3'h5;
    localparam int         PRESCALE_DIV   = 12;
    localparam int         EXT_CLK_DIV    = 8;
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
    localparam logic [7:0]  LOW_MAX       = 8'hFF;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } pcm_sfr_req_t;

    typedef struct packed {
        logic        ovf_flag;
        logic        run_bit;
        logic [2:0]  mod_flag;
        logic        idle_suspend;
        logic        wd_enable;
        logic        wd_lock;
        logic [2:0]  timebase_sel;
        logic        ovf_irq_mask;
        logic [3:0]  prescale;
        logic [15:0] count;
        logic [7:0]  mod2_high;
        logic [2:0]  ecnt_sync;
        logic [2:0]  eclk_sync;
        logic [2:0]  ext_div;
        logic [7:0]  rdata;
        logic        irq;
        logic        wd_reset;
    } pcm_state_t;
endpackage
